// *** rtl/chg_irq_params.svh ***
/*
 Register offsets, field positions, reset values and state codes of the
 charger request and interrupt register bank.
 Assumes nothing; included by the package and the design files.
*/
`ifndef CHG_IRQ_PARAMS_SVH
`define CHG_IRQ_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_SETUP_COMPLETE 8'h04
`define OFS_MEASURE_REQUEST 8'h05
`define OFS_TYPEC_REQUEST 8'h06
`define OFS_EVENT_MASK 8'h07
`define OFS_FAULT_MASK_A 8'h08
`define OFS_FAULT_MASK_B 8'h09
`define OFS_EVENT_FLAGS 8'h0A
`define OFS_FAULT_FLAGS_A 8'h0B

// ****************************************
// reset values and implemented-bit masks
// ****************************************
`define RST_REG 8'h00
`define VALID_EVENT_MASK 8'hBF
`define VALID_FAULT_MASK_A 8'h7F
`define VALID_FAULT_MASK_B 8'h3F
`define VALID_FLAGS 8'h7F

// ****************************************
// field positions
// ****************************************
`define BIT_CONFIGURED 0
`define BIT_MEASURE 0
`define BIT_SOURCE_RESTART 0
`define BIT_ERROR_RECOVERY 1
`define BIT_AUTO_CLEAR 7
`define BIT_UNCONFIGURED 7
`define BIT_STATE_CHANGE 5
`define BIT_TC_ATTACH_IND 4
`define BIT_CHG_ATTACH_IND 3
`define BIT_TC_ATTACH_EV 2
`define BIT_CHG_ATTACH_EV 1
`define BIT_MEAS_DONE 0
`define BIT_PREATTACH_OV 6
`define BIT_ILIM_UV 5
`define BIT_ILIM 4

// ****************************************
// flag behaviour per bank
// ****************************************
`define EVENT_CLR_ANY 8'h27
`define EVENT_AUTO_ELIG 8'h18
`define FAULT_CLR_ANY 8'h00
`define FAULT_AUTO_ELIG 8'h7F

// ****************************************
// type-c state codes and sync width
// ****************************************
`define TC_ATTACHED_CC1 4'h8
`define TC_ATTACHED_CC2 4'hC
`define SYNC_W 13

`endif

// *** rtl/chg_irq_pkg.sv ***
/*
 Types of the charger request and interrupt register bank.
 Assumes the params header is on the include path.
*/
`include "chg_irq_params.svh"

package chg_irq_pkg;

   // measurement request sequencer, one-hot
   typedef enum logic [1:0] {
      MEAS_IDLE = 2'b01,
      MEAS_BUSY = 2'b10
   } meas_state_t;

   // state of one flag bank
   typedef struct packed {
      logic [7:0] flags;
   } bank_state_t;

   // whole state of the control module
   typedef struct packed {
      logic [`SYNC_W-1:0] sync1;
      logic [`SYNC_W-1:0] sync2;
      logic [3:0] state_prev;
      logic tc_att_prev;
      logic bc_att_prev;
      logic configured;
      meas_state_t meas;
      logic [7:0] ev_mask;
      logic [7:0] fa_mask;
      logic [7:0] fb_mask;
      logic [7:0] rdata;
      logic start_p;
      logic ferr_p;
      logic frst_p;
      logic irq;
   } ctrl_state_t;

endpackage

// *** rtl/chg_irq_regs.sv ***
/*
 Charger configuration gate, measurement request, type-c requests,
 interrupt masks and the event and first fault flag registers.
 Assumes a host-side serial slave presents byte accesses on the register
 port in the clock domain, and converter logic drives meas_done on it.
*/
// Operation
// - converter held off until configured written one
// - unconfigured flag reads inverse of configured
// - measure request write one starts sampling
// - request stays set until sampling done
// - done flag set on data, read clears
// - bit one forces error recovery, reads zero
// - bit zero restarts unattached source, reads zero
// - flags reach interrupt only when masked in
// - all mask bits reset to zero
// - auto-clear bit selects latched or self-clearing flags
// - state and attach events clear on read
// - state change flag set on any transition
// - attach events set on attach status edges
// - type-c indicator while attached source attached
// - charger indicator shows data pin attach
// - read clears fault only once resolved
// - preattach overvoltage needs enabled, unattached, overvoltage
// - trip select suppresses one current flag
`timescale 1ns/1ps
`default_nettype none
`include "chg_irq_params.svh"

module chg_irq_regs
   import chg_irq_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // converter and measurement
   output logic converter_allow,
   output logic meas_start,
   input wire logic meas_done,
   // type-c state machine
   output logic force_error_recovery,
   output logic force_source_restart,
   input wire logic [3:0] typec_state,
   input wire logic typec_attach_status,
   input wire logic typec_detect_enable,
   // charger detection on protected_data_plus / protected_data_minus
   input wire logic charger_attach_status,
   // fault conditions
   input wire logic bus_power_monitor_input,
   input wire logic ilim_uv_cond,
   input wire logic ilim_cond,
   input wire logic [3:0] other_fault_cond,
   input wire logic current_trip_select,
   // interrupt
   output logic irq
);
   ctrl_state_t st_reg;
   ctrl_state_t st_next;
   flag_bank_if ev_if ();
   flag_bank_if fa_if ();

   // ****************************************
   // synchronised inputs
   // ****************************************
   logic [3:0] tc_state_s;
   logic tc_att_s;
   logic bc_att_s;
   logic bus_ov_s;
   logic ilim_uv_s;
   logic ilim_s;
   logic [3:0] other_s;
   logic tc_attached_src;
   logic wr_hit;
   logic rd_hit;

   // only the second stage is read; the state bus is assumed to move slowly
   always_comb begin
      {tc_state_s, tc_att_s, bc_att_s, bus_ov_s, ilim_uv_s, ilim_s, other_s} = st_reg.sync2;
      tc_attached_src = (tc_state_s == `TC_ATTACHED_CC1) || (tc_state_s == `TC_ATTACHED_CC2);
   end

   // ****************************************
   // flag sources
   // ****************************************
   // event bank: pulses for events, levels for the two indicators
   always_comb begin
      ev_if.set = 8'h00;
      ev_if.set[`BIT_STATE_CHANGE] = tc_state_s != st_reg.state_prev;
      ev_if.set[`BIT_TC_ATTACH_IND] = tc_att_s && tc_attached_src;
      ev_if.set[`BIT_CHG_ATTACH_IND] = bc_att_s;
      ev_if.set[`BIT_TC_ATTACH_EV] = tc_att_s != st_reg.tc_att_prev;
      ev_if.set[`BIT_CHG_ATTACH_EV] = bc_att_s != st_reg.bc_att_prev;
      ev_if.set[`BIT_MEAS_DONE] = meas_done && (st_reg.meas == MEAS_BUSY);
      ev_if.cond = 8'h00;
      ev_if.cond[`BIT_TC_ATTACH_IND] = ev_if.set[`BIT_TC_ATTACH_IND];
      ev_if.cond[`BIT_CHG_ATTACH_IND] = ev_if.set[`BIT_CHG_ATTACH_IND];
      ev_if.rd_clr = rd_hit && (reg_addr == `OFS_EVENT_FLAGS);
      ev_if.auto_en = st_reg.ev_mask[`BIT_AUTO_CLEAR];
   end

   // fault bank: every bit is a live condition
   always_comb begin
      fa_if.cond = {1'b0, 3'b000, other_s};
      fa_if.cond[`BIT_PREATTACH_OV] = bus_ov_s && typec_detect_enable && !tc_att_s;
      fa_if.cond[`BIT_ILIM_UV] = ilim_uv_s && !current_trip_select;
      fa_if.cond[`BIT_ILIM] = ilim_s && current_trip_select;
      fa_if.set = fa_if.cond;
      fa_if.rd_clr = rd_hit && (reg_addr == `OFS_FAULT_FLAGS_A);
      fa_if.auto_en = st_reg.ev_mask[`BIT_AUTO_CLEAR];
   end

   flag_bank #(
      .CLR_ANY(`EVENT_CLR_ANY),
      .AUTO_ELIG(`EVENT_AUTO_ELIG)
   ) u_event_bank (
      .clock(clock),
      .arst_n(arst_n),
      .fb(ev_if.bank)
   );

   flag_bank #(
      .CLR_ANY(`FAULT_CLR_ANY),
      .AUTO_ELIG(`FAULT_AUTO_ELIG)
   ) u_fault_bank (
      .clock(clock),
      .arst_n(arst_n),
      .fb(fa_if.bank)
   );

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      wr_hit = reg_wr;
      rd_hit = reg_rd && !reg_wr; // a write wins a collision on the port
      st_next = st_reg;
      st_next.sync1 = {typec_state, typec_attach_status, charger_attach_status,
         bus_power_monitor_input, ilim_uv_cond, ilim_cond, other_fault_cond};
      st_next.sync2 = st_reg.sync1;
      st_next.state_prev = tc_state_s;
      st_next.tc_att_prev = tc_att_s;
      st_next.bc_att_prev = bc_att_s;
      st_next.start_p = 1'b0;
      st_next.ferr_p = 1'b0;
      st_next.frst_p = 1'b0;
      // measurement sequencer: completion drops the request bit
      case (st_reg.meas)
         MEAS_IDLE: begin
            st_next.meas = MEAS_IDLE;
         end
         MEAS_BUSY: begin
            if (meas_done) begin
               st_next.meas = MEAS_IDLE;
            end
         end
         default: begin
            st_next.meas = MEAS_IDLE;
         end
      endcase
      // register writes; a new request wins over a completion
      if (wr_hit) begin
         case (reg_addr)
            `OFS_SETUP_COMPLETE: begin
               st_next.configured = reg_wdata[`BIT_CONFIGURED];
            end
            `OFS_MEASURE_REQUEST: begin
               if (reg_wdata[`BIT_MEASURE]) begin
                  st_next.meas = MEAS_BUSY;
                  st_next.start_p = 1'b1;
               end
            end
            `OFS_TYPEC_REQUEST: begin
               st_next.ferr_p = reg_wdata[`BIT_ERROR_RECOVERY];
               st_next.frst_p = reg_wdata[`BIT_SOURCE_RESTART];
            end
            `OFS_EVENT_MASK: begin
               st_next.ev_mask = reg_wdata & `VALID_EVENT_MASK;
            end
            `OFS_FAULT_MASK_A: begin
               st_next.fa_mask = reg_wdata & `VALID_FAULT_MASK_A;
            end
            `OFS_FAULT_MASK_B: begin
               st_next.fb_mask = reg_wdata & `VALID_FAULT_MASK_B;
            end
            default: begin
               st_next.configured = st_reg.configured;
            end
         endcase
      end
      // read data is captured before the read side effects land
      if (rd_hit) begin
         case (reg_addr)
            `OFS_SETUP_COMPLETE: st_next.rdata = {7'h00, st_reg.configured};
            `OFS_MEASURE_REQUEST: st_next.rdata = {7'h00, st_reg.meas == MEAS_BUSY};
            `OFS_TYPEC_REQUEST: st_next.rdata = 8'h00;
            `OFS_EVENT_MASK: st_next.rdata = st_reg.ev_mask;
            `OFS_FAULT_MASK_A: st_next.rdata = st_reg.fa_mask;
            `OFS_FAULT_MASK_B: st_next.rdata = st_reg.fb_mask;
            `OFS_EVENT_FLAGS: st_next.rdata = {!st_reg.configured, ev_if.flags[6:0]};
            `OFS_FAULT_FLAGS_A: st_next.rdata = {1'b0, fa_if.flags[6:0]};
            default: st_next.rdata = 8'h00;
         endcase
      end
      // masked flags only; the auto-clear control bit is not a flag
      st_next.irq = |(ev_if.flags[6:0] & st_reg.ev_mask[6:0])
         || |(fa_if.flags[6:0] & st_reg.fa_mask[6:0]);
   end

   // ****************************************
   // state register
   // ****************************************
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
         st_reg.meas <= MEAS_IDLE;
         st_reg.ev_mask <= `RST_REG;
         st_reg.fa_mask <= `RST_REG;
         st_reg.fb_mask <= `RST_REG;
      end else begin
         st_reg <= st_next;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign reg_rdata = st_reg.rdata;
   assign converter_allow = st_reg.configured;
   assign meas_start = st_reg.start_p;
   assign force_error_recovery = st_reg.ferr_p;
   assign force_source_restart = st_reg.frst_p;
   assign irq = st_reg.irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!arst_n);

   sequence cfg_write_s;
      reg_wr && reg_addr == `OFS_SETUP_COMPLETE;
   endsequence

   sequence meas_req_s;
      reg_wr && reg_addr == `OFS_MEASURE_REQUEST && reg_wdata[0];
   endsequence

   cfg_gate_a: assert property (cfg_write_s |=> converter_allow == $past(reg_wdata[0]))
      else $error("converter gate does not follow configured write");
   unconf_read_a: assert property (rd_hit && reg_addr == `OFS_EVENT_FLAGS
      |=> reg_rdata[7] == !$past(converter_allow))
      else $error("unconfigured flag wrong on read");
   meas_start_a: assert property (meas_req_s |=> meas_start && st_reg.meas == MEAS_BUSY)
      else $error("measurement request did not start sampling");
   meas_hold_a: assert property (st_reg.meas == MEAS_BUSY && !meas_done
      |=> st_reg.meas == MEAS_BUSY)
      else $error("measurement request dropped early");
   meas_done_a: assert property (st_reg.meas == MEAS_BUSY && meas_done && !wr_hit
      |=> st_reg.meas == MEAS_IDLE ##0 ev_if.flags[0])
      else $error("completion did not clear request and set done flag");
   tc_read_zero_a: assert property (rd_hit && reg_addr == `OFS_TYPEC_REQUEST
      |=> reg_rdata == 8'h00)
      else $error("type-c request reads nonzero");
   tc_req_pulse_a: assert property (reg_wr && reg_addr == `OFS_TYPEC_REQUEST
      |=> force_source_restart == $past(reg_wdata[0])
      ##1 (!force_source_restart || $past(reg_wr)))
      else $error("source restart pulse wrong");
   mask_gate_a: assert property ((ev_if.flags[6:0] & st_reg.ev_mask[6:0]) == 7'h00
      && (fa_if.flags[6:0] & st_reg.fa_mask[6:0]) == 7'h00 |=> !irq)
      else $error("interrupt raised with all flags masked off");
   state_change_a: assert property (tc_state_s != st_reg.state_prev
      |=> ev_if.flags[5])
      else $error("state change not flagged");
   trip_sel_a: assert property (current_trip_select && $past(current_trip_select)
      |-> !$rose(fa_if.flags[5]))
      else $error("suppressed current flag rose");
   preatt_ov_a: assert property (fa_if.cond[6] |=> fa_if.flags[6])
      else $error("preattach overvoltage not flagged");

   // ****************************************
   // flag and pulse checks
   // ****************************************
   // back-to-back request writes are legal, so pulse checks key on the
   // write strobe of the cycle before rather than on a fixed pulse width
   // error recovery pulse follows the written bit
   err_pulse_a: assert property (reg_wr && reg_addr == `OFS_TYPEC_REQUEST
      |=> force_error_recovery == $past(reg_wdata[1]))
      else $error("error recovery pulse wrong");
   // no request pulse without a write the cycle before
   pulse_idle_a: assert property (!$past(reg_wr)
      |-> !force_error_recovery && !force_source_restart)
      else $error("request pulse without write");
   // event bits clear on read unless a new event lands
   ev_clear_a: assert property (ev_if.rd_clr && ev_if.set[5] == 1'b0
      && ev_if.set[2:0] == 3'b000 |=> ev_if.flags[5] == 1'b0 && ev_if.flags[2:0] == 3'b000)
      else $error("event flag survived read");
   // type-c attach edge raises its event flag
   tc_edge_a: assert property (tc_att_s != st_reg.tc_att_prev |=> ev_if.flags[2])
      else $error("type-c attach edge not flagged");
   // charger attach edge raises its event flag
   bc_edge_a: assert property (bc_att_s != st_reg.bc_att_prev |=> ev_if.flags[1])
      else $error("charger attach edge not flagged");
   // a steady attach level does not raise the event flag
   tc_quiet_a: assert property (tc_att_s == st_reg.tc_att_prev && !ev_if.flags[2]
      |=> !ev_if.flags[2])
      else $error("attach event without edge");
   // indicator follows attach in an attached source state
   tc_ind_a: assert property (tc_att_s && tc_attached_src |=> ev_if.flags[4])
      else $error("type-c indicator missing");
   // charger indicator follows data pin attach
   chg_ind_a: assert property (bc_att_s |=> ev_if.flags[3])
      else $error("charger indicator missing");
   // auto-clear drops an indicator once its condition is gone
   auto_clear_a: assert property (ev_if.auto_en && !ev_if.cond[3] |=> !ev_if.flags[3])
      else $error("indicator not auto-cleared");
   // without auto-clear an indicator stays latched until read
   latch_hold_a: assert property (!ev_if.auto_en && !ev_if.rd_clr && ev_if.flags[3]
      |=> ev_if.flags[3])
      else $error("latched indicator lost");
   // a resolved fault clears on read
   fault_clear_a: assert property (fa_if.rd_clr && !fa_if.cond[0] |=> !fa_if.flags[0])
      else $error("resolved fault kept after read");
   // an enabled flag reaches the interrupt a cycle later
   mask_pass_a: assert property ((ev_if.flags[6:0] & st_reg.ev_mask[6:0]) != 7'h00
      |=> irq)
      else $error("enabled flag did not raise interrupt");
   // reserved positions never hold a one
   reserved_zero_a: assert property (ev_if.flags[7:6] == 2'b00 && fa_if.flags[7] == 1'b0
      && st_reg.ev_mask[6] == 1'b0 && st_reg.fa_mask[7] == 1'b0)
      else $error("reserved bit set");
endmodule

`default_nettype wire

// *** rtl/flag_bank.sv ***
/*
 One eight-bit sticky flag register with clear-on-read and auto-clear.
 Assumes set and cond come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "chg_irq_params.svh"

module flag_bank
   import chg_irq_pkg::*;
#(
   parameter logic [7:0] CLR_ANY = 8'h00,
   parameter logic [7:0] AUTO_ELIG = 8'h00
) (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // flag carrier
   flag_bank_if.bank fb
);
   bank_state_t st_reg;
   bank_state_t st_next;
   logic [7:0] clr;
   logic [7:0] live_keep;

   // read clears unconditional bits, others only once resolved; set wins
   always_comb begin
      clr = ({8{fb.rd_clr}} & (CLR_ANY | ~fb.cond))
         | ({8{fb.auto_en}} & AUTO_ELIG & ~fb.cond);
      st_next.flags = (fb.set | (st_reg.flags & ~clr)) & `VALID_FLAGS;
      // flags a read must leave alone, watched by the check below
      live_keep = fb.cond & ~CLR_ANY & st_reg.flags;
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign fb.flags = st_reg.flags;

   // a read must not drop a flag whose condition is still present
   cond_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
      fb.rd_clr |=> ((st_reg.flags & $past(live_keep)) == $past(live_keep)))
      else $error("flag with live condition cleared by read");
endmodule

`default_nettype wire

// *** rtl/flag_bank_if.sv ***
/*
 Carrier between the control module and one flag bank.
 Assumes a single clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none

interface flag_bank_if;
   logic [7:0] set;
   logic [7:0] cond;
   logic rd_clr;
   logic auto_en;
   logic [7:0] flags;

   modport ctrl (output set, output cond, output rd_clr, output auto_en, input flags);
   modport bank (input set, input cond, input rd_clr, input auto_en, output flags);
endinterface

`default_nettype wire

// *** tb/meas_model.sv ***
/*
 Converter sampling model: answers the latest start pulse with a one-cycle done.
 Assumes the clock of the register bank and a delay chosen by the bench.
*/
`timescale 1ns/1ps
`default_nettype none

module meas_model (
   // clock and reset
   input wire logic clock,
   input wire logic arst_n,
   // sample handshake
   input wire logic meas_start,
   input wire logic [7:0] delay,
   output logic meas_done
);
   // *****
   // sample timer
   // *****
   logic [7:0] cnt_reg;

   // a new start reloads the timer, so a restart drops the old sample
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 8'h00;
      end else if (meas_start) begin
         cnt_reg <= delay;
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end

   // done only in the last timer cycle; low while idle
   assign meas_done = (cnt_reg == 8'h01);
endmodule

`default_nettype wire

// *** tb/tb_top.sv ***
/*
 Self-checking bench for the charger request and interrupt register bank.
 Assumes the package, the params header and the sampling model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import chg_irq_pkg::*;

   // *****
   // signals
   // *****
   logic clock, arst_n, reg_wr, reg_rd, converter_allow, meas_start, meas_done, irq;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, delay;
   logic force_error_recovery, force_source_restart, typec_attach_status, typec_detect_enable;
   logic charger_attach_status, bus_power_monitor_input, ilim_uv_cond, ilim_cond;
   logic current_trip_select;
   logic [3:0] typec_state, other_fault_cond;
   int n_mismatch, checks_done, cyc;

   chg_irq_regs u_chg_irq_regs (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .converter_allow(converter_allow), .meas_start(meas_start), .meas_done(meas_done),
      .force_error_recovery(force_error_recovery), .force_source_restart(force_source_restart),
      .typec_state(typec_state), .typec_attach_status(typec_attach_status),
      .typec_detect_enable(typec_detect_enable), .charger_attach_status(charger_attach_status),
      .bus_power_monitor_input(bus_power_monitor_input), .ilim_uv_cond(ilim_uv_cond),
      .ilim_cond(ilim_cond), .other_fault_cond(other_fault_cond),
      .current_trip_select(current_trip_select), .irq(irq));

   meas_model u_meas_model (.clock(clock), .arst_n(arst_n), .meas_start(meas_start),
      .delay(delay), .meas_done(meas_done));

   // *****
   // helpers
   // *****
   // ends on a rising edge so callers can drive by non-blocking assignment
   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] a);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: reg %h got %h want %h", $time, a, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
      end
   endtask

   // one-cycle strobe; returns just after the taking edge so pulses can be seen
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk8(reg_rdata, exp, a);
   endtask

   task automatic stop_test;
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // *****
   // scenarios
   // *****
   task automatic t_reset;
      logic [7:0] a;
      chk1(converter_allow, 1'b0, "allow");
      rd_chk(8'h0A, 8'h80);
      for (a = 8'h04; a < 8'h0C; a++) begin
         if (a != 8'h0A) rd_chk(a, 8'h00);
      end
      rd_chk(8'h0F, 8'h00);
   endtask

   task automatic t_config;
      wr(8'h04, 8'hFF);
      chk1(converter_allow, 1'b1, "allow");
      rd_chk(8'h04, 8'h01);
      rd_chk(8'h0A, 8'h00);
   endtask

   task automatic t_masks;
      wr(8'h07, 8'hFF);
      wr(8'h08, 8'hFF);
      wr(8'h09, 8'hFF);
      rd_chk(8'h07, 8'hBF);
      rd_chk(8'h08, 8'h7F);
      rd_chk(8'h09, 8'h3F);
      wr(8'h07, 8'h00);
      wr(8'h08, 8'h00);
      wr(8'h09, 8'h00);
   endtask

   task automatic t_typec_req;
      wr(8'h06, 8'h02);
      chk1(force_error_recovery, 1'b1, "err");
      chk1(force_source_restart, 1'b0, "rst");
      wr(8'h06, 8'h01);
      chk1(force_source_restart, 1'b1, "rst");
      chk1(force_error_recovery, 1'b0, "err");
      rd_chk(8'h06, 8'h00);
   endtask

   // slow answer checks the busy bit; prompt answer checks the masked interrupt
   task automatic t_meas(input logic [7:0] dly, input logic masked);
      int i;
      delay <= dly;
      wr(8'h07, {7'h00, masked});
      wr(8'h05, 8'h01);
      chk1(meas_start, 1'b1, "start");
      if (!masked) rd_chk(8'h05, 8'h01);
      for (i = 0; i < 100 && meas_done !== 1'b1; i++) begin
         cycles(1);
         #1;
      end
      cycles(2);
      #1;
      chk1(irq, masked, "irq");
      rd_chk(8'h05, 8'h00);
      rd_chk(8'h0A, 8'h01);
      rd_chk(8'h0A, 8'h00);
      chk1(irq, 1'b0, "irq");
      wr(8'h07, 8'h00);
   endtask

   task automatic t_events;
      cycles(1);
      typec_state <= 4'h3;
      cycles(6);
      rd_chk(8'h0A, 8'h20);
      rd_chk(8'h0A, 8'h00);
      cycles(1);
      typec_attach_status <= 1'b1;
      cycles(6);
      rd_chk(8'h0A, 8'h04);
      cycles(1);
      typec_state <= 4'h8;
      cycles(6);
      rd_chk(8'h0A, 8'h30);
      cycles(1);
      charger_attach_status <= 1'b1;
      cycles(6);
      rd_chk(8'h0A, 8'h1A);
      cycles(1);
      typec_attach_status <= 1'b0;
      cycles(6);
      rd_chk(8'h0A, 8'h1C);
      rd_chk(8'h0A, 8'h08);
      wr(8'h07, 8'h80);
      cycles(1);
      charger_attach_status <= 1'b0;
      cycles(6);
      rd_chk(8'h0A, 8'h02);
      wr(8'h07, 8'h00);
   endtask

   task automatic t_faults;
      cycles(1);
      typec_detect_enable <= 1'b1;
      bus_power_monitor_input <= 1'b1;
      other_fault_cond <= 4'h5;
      cycles(6);
      rd_chk(8'h0B, 8'h45);
      rd_chk(8'h0B, 8'h45);
      cycles(1);
      bus_power_monitor_input <= 1'b0;
      other_fault_cond <= 4'h0;
      cycles(6);
      rd_chk(8'h0B, 8'h45);
      rd_chk(8'h0B, 8'h00);
      cycles(1);
      typec_detect_enable <= 1'b0;
      bus_power_monitor_input <= 1'b1;
      cycles(6);
      rd_chk(8'h0B, 8'h00);
      cycles(1);
      bus_power_monitor_input <= 1'b0;
      current_trip_select <= 1'b1;
      ilim_uv_cond <= 1'b1;
      ilim_cond <= 1'b1;
      cycles(6);
      rd_chk(8'h0B, 8'h10);
      cycles(1);
      current_trip_select <= 1'b0;
      cycles(6);
      rd_chk(8'h0B, 8'h30);
      rd_chk(8'h0B, 8'h20);
      wr(8'h08, 8'h10);
      cycles(2);
      #1;
      chk1(irq, 1'b0, "irq");
      wr(8'h08, 8'h20);
      cycles(2);
      #1;
      chk1(irq, 1'b1, "irq");
      wr(8'h07, 8'h80);
      cycles(1);
      ilim_uv_cond <= 1'b0;
      ilim_cond <= 1'b0;
      cycles(6);
      #1;
      chk1(irq, 1'b0, "irq");
      wr(8'h07, 8'h00);
   endtask

   // quiet the inputs first so the second reset leaves no stale event behind
   task automatic t_rerst;
      cycles(1);
      typec_state <= 4'h0;
      cycles(6);
      arst_n <= 1'b0;
      cycles(2);
      #1;
      chk1(converter_allow, 1'b0, "allow");
      cycles(1);
      arst_n <= 1'b1;
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h08, 8'h00);
      rd_chk(8'h0A, 8'h80);
   endtask

   // *****
   // clock, watchdog and main sequence
   // *****
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // the whole run needs well under two thousand cycles
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         $display("mismatch at %0t: timeout", $time);
         stop_test();
      end
   end

   initial begin
      n_mismatch = 0;
      checks_done = 0;
      cyc = 0;
      arst_n = 1'b0;
      {reg_wr, reg_rd, typec_attach_status, typec_detect_enable} = 4'h0;
      {charger_attach_status, bus_power_monitor_input, ilim_uv_cond, ilim_cond} = 4'h0;
      current_trip_select = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      delay = 8'h1E;
      typec_state = 4'h0;
      other_fault_cond = 4'h0;
      cycles(8);
      arst_n <= 1'b1;
      t_reset();
      t_config();
      t_masks();
      t_typec_req();
      t_meas(8'h1E, 1'b0);
      t_meas(8'h01, 1'b1);
      t_events();
      t_faults();
      t_rerst();
      stop_test();
   end
endmodule

`default_nettype wire
